// ===== src/audio_pulse_modulator.sv
`timescale 1ns/1ps

module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  output logic [WIDTH-1:0] o_data,
  output logic o_valid,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("sample_fifo depth must be a power of two");
  end

  // Full at DEPTH entries; a push while full is simply not taken
  assign o_ready = (count != (AW+1)'(DEPTH));
  assign o_valid = (count != '0);
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module audio_pulse_modulator #(
  parameter int FIFO_DEPTH = pulse_mod_pkg::FIFO_DEPTH
) (
  input wire logic I_CLOCK,
  input wire logic I_ARST_N,
  input wire logic [15:0] I_DATA_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WRITE,
  input wire logic I_READ,
  input wire logic [7:0] I_SFR_ADDR,
  input wire logic [7:0] I_SFR_WDATA,
  input wire logic I_SFR_WRITE,
  input wire logic I_GLOBAL_IRQ_ENABLE,
  output logic [7:0] O_RDATA,
  output logic O_SAMPLE_READY,
  output logic O_FIRST_PULSE_OUTPUT,
  output logic O_SECOND_PULSE_OUTPUT,
  output logic O_PERIOD_DONE_FLAG,
  output logic O_PERIOD_DONE_MASK,
  output logic O_IRQ
);
  pulse_mod_pkg::control_s control;
  logic [7:0] rate_adjust;
  logic [7:0] sample_value;
  logic [7:0] active_sample;
  logic period_done_flag;
  logic period_done_mask;
  pulse_mod_pkg::phase_e phase;
  logic [2:0] div_cnt;
  logic [7:0] slot_cnt;
  logic [8:0] wait_cnt;
  logic slot_tick;
  logic period_end;
  logic [7:0] fifo_data;
  logic fifo_valid;
  logic fifo_ready;
  logic wr_control;
  logic wr_adjust;
  logic wr_sample;
  logic pulse_high;
  logic [2:0] div_max;
  pulse_mod_pkg::bus_req_s cpu_req;

  // The queue needs at least two entries to decouple writes from period ends
  if (FIFO_DEPTH < 2) begin : g_bad_fifo_depth
    $error("audio_pulse_modulator fifo depth out of range");
  end

  // The external-move access travels as one request word
  assign cpu_req.addr = I_DATA_ADDR;
  assign cpu_req.data = I_WDATA;
  assign cpu_req.write = I_WRITE;
  assign cpu_req.read = I_READ;

  // CPU-side writes within the internally mapped page
  assign wr_control = cpu_req.write && (cpu_req.addr == pulse_mod_pkg::ADDR_CONTROL);
  assign wr_adjust = cpu_req.write && (cpu_req.addr == pulse_mod_pkg::ADDR_ADJUST);
  assign wr_sample = cpu_req.write && (cpu_req.addr == pulse_mod_pkg::ADDR_SAMPLE);

  // Write-only control and adjust; the sample register also feeds the queue
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      control.output_enable <= pulse_mod_pkg::CONTROL_RESET[pulse_mod_pkg::OUT_EN_BIT];
      control.rate_adjust_enable <= pulse_mod_pkg::CONTROL_RESET[pulse_mod_pkg::ADJ_EN_BIT];
      control.period_select <= pulse_mod_pkg::CONTROL_RESET[pulse_mod_pkg::SEL_LSB +: 3];
      rate_adjust <= pulse_mod_pkg::ADJUST_RESET;
      sample_value <= pulse_mod_pkg::SAMPLE_RESET;
    end else begin
      if (wr_control) begin
        control.output_enable <= cpu_req.data[pulse_mod_pkg::OUT_EN_BIT];
        control.rate_adjust_enable <= cpu_req.data[pulse_mod_pkg::ADJ_EN_BIT];
        control.period_select <= cpu_req.data[pulse_mod_pkg::SEL_LSB +: 3];
      end
      if (wr_adjust) begin
        rate_adjust <= cpu_req.data;
      end
      if (wr_sample) begin
        sample_value <= cpu_req.data;
      end
    end
  end

  // Only the sample register reads back; write-only locations read zero
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_RDATA <= 8'h00;
    end else if (cpu_req.read && cpu_req.addr == pulse_mod_pkg::ADDR_SAMPLE) begin
      O_RDATA <= sample_value;
    end else begin
      O_RDATA <= 8'h00;
    end
  end

  // Written samples queue here; the modulator takes one per period end
  sample_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(I_CLOCK),
    .arst_n(I_ARST_N),
    .i_data(cpu_req.data),
    .i_valid(wr_sample),
    .o_ready(fifo_ready),
    .o_data(fifo_data),
    .o_valid(fifo_valid),
    .i_ready(period_end)
  );

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_SAMPLE_READY <= 1'b0;
    end else begin
      O_SAMPLE_READY <= fifo_ready;
    end
  end

  // Prescaler: one slot every (8 - select) clocks
  // A select change mid-slot may wrap the count once, delaying one slot
  assign div_max = pulse_mod_pkg::SEL_MAX - control.period_select;
  assign slot_tick = (div_cnt == div_max);

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      div_cnt <= 3'h0;
    end else if (slot_tick) begin
      div_cnt <= 3'h0;
    end else begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  // Period: 256 base slots, then optional wait slots
  // Adjust is read when the base slots run out, so a late write still counts
  assign period_end = slot_tick && (
    (phase == pulse_mod_pkg::ST_BASE && slot_cnt == 8'hff && !control.rate_adjust_enable) ||
    (phase == pulse_mod_pkg::ST_WAIT && wait_cnt == 9'h001));

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      phase <= pulse_mod_pkg::ST_BASE;
      slot_cnt <= 8'h00;
      wait_cnt <= 9'h000;
    end else if (slot_tick) begin
      case (phase)
        pulse_mod_pkg::ST_BASE: begin
          slot_cnt <= slot_cnt + 8'h01;
          if (slot_cnt == 8'hff && control.rate_adjust_enable) begin
            phase <= pulse_mod_pkg::ST_WAIT;
            wait_cnt <= pulse_mod_pkg::BASE_SLOTS - {1'b0, rate_adjust};
          end
        end
        pulse_mod_pkg::ST_WAIT: begin
          wait_cnt <= wait_cnt - 9'h001;
          if (wait_cnt == 9'h001) begin
            phase <= pulse_mod_pkg::ST_BASE;
          end
        end
        default: begin
          phase <= pulse_mod_pkg::ST_BASE;
        end
      endcase
    end
  end

  // The period's sample is latched only at a period boundary
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      active_sample <= pulse_mod_pkg::SAMPLE_RESET;
    end else if (period_end && fifo_valid) begin
      active_sample <= fifo_data;
    end else begin
      active_sample <= active_sample;
    end
  end

  // Top bit 0: width shrinks as value rises; top bit 1: width grows with value
  assign pulse_high = (phase == pulse_mod_pkg::ST_BASE) && (active_sample[7] ?
    (slot_cnt[6:0] < active_sample[6:0]) :
    (slot_cnt[6:0] < ~active_sample[6:0]));

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_FIRST_PULSE_OUTPUT <= 1'b0;
      O_SECOND_PULSE_OUTPUT <= 1'b0;
    end else begin
      O_FIRST_PULSE_OUTPUT <= control.output_enable && !active_sample[7] && pulse_high;
      O_SECOND_PULSE_OUTPUT <= control.output_enable && active_sample[7] && pulse_high;
    end
  end

  // Request flag: set wins over a same-cycle clear, so no period end is lost
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      period_done_flag <= 1'b0;
    end else begin
      if (period_end) begin
        period_done_flag <= 1'b1;
      end else if (I_SFR_WRITE && I_SFR_ADDR == pulse_mod_pkg::ADDR_IRQ_REQ &&
                   !I_SFR_WDATA[pulse_mod_pkg::DONE_BIT]) begin
        period_done_flag <= 1'b0;
      end
    end
  end

  // Local copy of this source's bit in the shared mask register
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      period_done_mask <= 1'b0;
    end else if (I_SFR_WRITE && I_SFR_ADDR == pulse_mod_pkg::ADDR_IRQ_MASK) begin
      period_done_mask <= I_SFR_WDATA[pulse_mod_pkg::DONE_BIT];
    end
  end

  // Flag and mask pins repeat internal state one clock later; IRQ registers flag AND mask AND global enable, also from a flop
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_PERIOD_DONE_FLAG <= 1'b0;
      O_PERIOD_DONE_MASK <= 1'b0;
      O_IRQ <= 1'b0;
    end else begin
      O_PERIOD_DONE_FLAG <= period_done_flag;
      O_PERIOD_DONE_MASK <= period_done_mask;
      O_IRQ <= period_done_flag && period_done_mask && I_GLOBAL_IRQ_ENABLE;
    end
  end
endmodule

// ===== src/pulse_mod_pkg.sv
package pulse_mod_pkg;
  localparam logic [15:0] ADDR_CONTROL = 16'hffe0;
  localparam logic [15:0] ADDR_ADJUST = 16'hffe1;
  localparam logic [15:0] ADDR_SAMPLE = 16'hffe2;
  localparam logic [7:0] ADDR_IRQ_REQ = 8'hfe;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hfd;
  localparam int SEL_LSB = 0;
  localparam int ADJ_EN_BIT = 3;
  localparam int OUT_EN_BIT = 4;
  localparam int DONE_BIT = 4;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] ADJUST_RESET = 8'h00;
  localparam logic [7:0] SAMPLE_RESET = 8'h00;
  localparam logic [2:0] SEL_MAX = 3'h7;
  localparam logic [8:0] BASE_SLOTS = 9'h100;
  localparam int FIFO_DEPTH = 32;

  typedef struct packed {
    logic output_enable;
    logic rate_adjust_enable;
    logic [2:0] period_select;
  } control_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic write;
    logic read;
  } bus_req_s;

  typedef enum logic [1:0] {
    ST_BASE = 2'b01,
    ST_WAIT = 2'b10
  } phase_e;
endpackage

// ===== sim/audio_pulse_modulator_asserts.sv
`timescale 1ns/1ps
module apm_checker (
  input wire logic I_CLOCK,
  input wire logic I_ARST_N,
  input wire logic [15:0] I_DATA_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WRITE,
  input wire logic I_READ,
  input wire logic [7:0] I_SFR_ADDR,
  input wire logic [7:0] I_SFR_WDATA,
  input wire logic I_SFR_WRITE,
  input wire logic I_GLOBAL_IRQ_ENABLE,
  input wire logic [7:0] O_RDATA,
  input wire logic O_FIRST_PULSE_OUTPUT,
  input wire logic O_SECOND_PULSE_OUTPUT,
  input wire logic O_PERIOD_DONE_FLAG,
  input wire logic O_PERIOD_DONE_MASK,
  input wire logic O_IRQ
);
  logic en;
  wire rs = I_READ && I_DATA_ADDR == 16'hffe2;
  wire clr = I_SFR_WRITE && I_SFR_ADDR == 8'hfe && !I_SFR_WDATA[4];
  wire ms = I_SFR_WRITE && I_SFR_ADDR == 8'hfd && I_SFR_WDATA[4];
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_ARST_N);
  // Output enable as last written
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N)
      en <= 1'b0;
    else if (I_WRITE && I_DATA_ADDR == 16'hffe0)
      en <= I_WDATA[4];
  end
  AST_RD_SRC: assert property (O_RDATA != 8'h00 |-> $past(rs))
    else $error("read data without read");
  AST_RD_WO: assert property (I_READ && !rs |=> O_RDATA == 8'h00)
    else $error("nonzero read data");
  AST_EXCL: assert property (!(O_FIRST_PULSE_OUTPUT && O_SECOND_PULSE_OUTPUT))
    else $error("both outputs high");
  AST_OFF: assert property (!en && !$past(en) && !$past(en, 2) |->
    !O_FIRST_PULSE_OUTPUT && !O_SECOND_PULSE_OUTPUT) else $error("output while off");
  AST_IRQ: assert property (O_IRQ |-> O_PERIOD_DONE_FLAG && O_PERIOD_DONE_MASK)
    else $error("irq without flag and mask");
  AST_GIE: assert property (!I_GLOBAL_IRQ_ENABLE [*2] |-> !O_IRQ)
    else $error("irq while disabled");
  AST_HOLD: assert property (O_PERIOD_DONE_FLAG && !clr && !$past(clr) |=> O_PERIOD_DONE_FLAG)
    else $error("flag lost");
  AST_MASK: assert property (ms |-> ##[1:2] O_PERIOD_DONE_MASK)
    else $error("mask not taken");
endmodule
bind audio_pulse_modulator apm_checker i_chk (.*);

// ===== sim/pulse_filter_model.sv
`timescale 1ns/1ps
module pulse_filter_model (
  input wire logic clk,
  input wire logic i_first,
  input wire logic i_second,
  input wire logic i_frame,
  output int o_hi_first,
  output int o_hi_second
);
  int acc_first = 0;
  int acc_second = 0;
  // Integrates high time of each output over one sample period
  always @(posedge clk) begin
    o_hi_first <= i_frame ? acc_first : o_hi_first;
    o_hi_second <= i_frame ? acc_second : o_hi_second;
    acc_first <= (i_frame ? 0 : acc_first) + int'(i_first);
    acc_second <= (i_frame ? 0 : acc_second) + int'(i_second);
  end
endmodule

// ===== sim/audio_pulse_modulator_bench.sv
`timescale 1ns/1ps
module audio_pulse_modulator_bench;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sfr_wr = 1'b0;
  logic global_irq_enable = 1'b0, mask_v = 1'b0, prev = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, sfr_addr = 8'h00, sfr_wdata = 8'h00, rdata;
  logic rdy, p0, p1, flag, msk, irq, rise;
  int cyc = 0, cnt = 0, per = 0, nrise = 0, hi0, hi1, n_mismatch = 0, compares = 0;
  logic [23:0] cfg [5] = '{24'h170000, 24'h1000ff, 24'h1f0000, 24'h1fff80, 24'h0f8055};
  assign rise = flag && !prev;
  always #20 clk = ~clk;
  audio_pulse_modulator i_dut (.I_CLOCK(clk), .I_ARST_N(rst_n), .I_DATA_ADDR(addr),
    .I_WDATA(wdata), .I_WRITE(wr), .I_READ(rd), .I_SFR_ADDR(sfr_addr),
    .I_SFR_WDATA(sfr_wdata), .I_SFR_WRITE(sfr_wr), .I_GLOBAL_IRQ_ENABLE(global_irq_enable),
    .O_RDATA(rdata), .O_SAMPLE_READY(rdy), .O_FIRST_PULSE_OUTPUT(p0),
    .O_SECOND_PULSE_OUTPUT(p1), .O_PERIOD_DONE_FLAG(flag), .O_PERIOD_DONE_MASK(msk), .O_IRQ(irq));
  pulse_filter_model i_filt (.clk(clk), .i_first(p0), .i_second(p1), .i_frame(rise),
    .o_hi_first(hi0), .o_hi_second(hi1));
  // Service routine: clear the request once seen, otherwise rewrite the mask
  always @(negedge clk) begin
    sfr_wr <= rst_n;
    sfr_addr <= flag ? 8'hfe : 8'hfd;
    sfr_wdata <= flag ? 8'h00 : {3'h0, mask_v, 4'h0};
  end
  always @(posedge clk) begin
    prev <= flag;
    cyc <= cyc + 1;
    cnt <= rise ? 1 : cnt + 1;
    nrise <= nrise + int'(rise);
    if (rise)
      per <= cnt;
    if (cyc == 80000) begin
      n_mismatch++;
      end_sim();
    end
  end
  function automatic logic [31:0] per_of(logic [23:0] c);
    return (c[19] ? 32'd512 - c[15:8] : 32'd256) * (32'd8 - c[18:16]);
  endfunction
  function automatic logic [31:0] hi_of(logic [23:0] c, logic o);
    logic [6:0] w;
    w = c[7] ? c[6:0] : ~c[6:0];
    return (c[20] && c[7] == o) ? 32'd2 * w * (32'd8 - c[18:16]) : 32'd0;
  endfunction
  task automatic check(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(logic [15:0] a, logic [7:0] d, logic w);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = w;
    rd = !w;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
  endtask
  task automatic rises(int k);
    int t;
    t = nrise + k;
    wait (nrise == t);
    @(negedge clk);
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    logic [23:0] c;
    logic [31:0] v;
    v = $urandom(32'h772b);
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    bus(16'hffe2, 8'h00, 1'b0);
    check(rdata, pulse_mod_pkg::SAMPLE_RESET);
    for (int i = 0; i < 7; i++) begin
      v = $urandom;
      c = (i < 5) ? cfg[i] : {4'h1, v[3:0], v[15:0]};
      mask_v = (i == 0) || (i != 1 && v[16]);
      global_irq_enable = (i == 0) || (i != 1 && v[17]);
      bus(16'hffe0, c[23:16], 1'b1);
      bus(16'hffe1, c[15:8], 1'b1);
      rises(1);
      bus(16'hffe2, c[7:0], 1'b1);
      bus(16'hffe2, 8'h00, 1'b0);
      check(rdata, c[7:0]);
      rises(3);
      check(per, per_of(c));
      check(hi0, hi_of(c, 1'b0));
      check(hi1, hi_of(c, 1'b1));
      check(flag, 1'b1);
      check(irq, mask_v && global_irq_enable);
      check(msk, mask_v);
      @(negedge clk);
      check(flag, 1'b0);
      check(irq, 1'b0);
      $display("test %0d done", i);
    end
    bus(16'hffe0, 8'h17, 1'b1);
    repeat (34) bus(16'hffe2, 8'h3c, 1'b1);
    repeat (2) @(negedge clk);
    check(rdy, 1'b0);
    rises(34);
    check(rdy, 1'b1);
    for (int k = 0; k < 4; k++) begin
      bus(16'hffe0 + 16'(k) + 16'(k >> 1), 8'h00, 1'b0);
      check(rdata, 8'h00);
    end
    $display("buffer and read test done");
    end_sim();
  end
endmodule
